//--- hw/fpd_fan_pwm.sv
// Purpose: fan pwm drive with one-second full-on start, duty source select and over-temperature flag
// Assumes: apb slave on CLK_I; temperature input arrives already digitised as a duty code plus open and over flags
// Notes: period and start length are counts of CLK_I; SLOT_CYC shortens them for simulation
//
// Function
// - The pwm output is active high, high meaning the fan switch is on.
// - Duty cycle runs from 30% to 100% of a fixed period.
// - The period is fixed, nominally 30 Hz, set by the timing parameter.
// - At 100% the output stays high the whole period, lower duty shortens the high time.
// - After power-up and each shutdown release the output runs at 100% for one second.
// - At the end of the start second the duty source select bit decides the duty source.
// - After reset the duty source is the temperature voltage input.
// - With the temperature input selected but open, duty is fixed at 39.33%.
// - A temperature input above its over level sets the over-temperature status bit 5.
// - The fault variant drives its active-low fault pin low while over-temperature lasts.
// - Software selects register duty by setting bit 5 of config and writing the duty code.
// - A 4-bit read/write duty register maps 0 to 30% and 15 to 100%, 2 giving 39.33%.
// - Only the shutdown bit stops the output, a stalled fan does not.
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "fpd_regs.svh"
module fpd_fan_pwm
  import fpd_pkg::*;
#(
  parameter int unsigned SLOT_CYC = `FPD_SLOT_CYC,
  parameter bit FAULT_VARIANT = 1'b1
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic [3:0] TEMP_VOLTAGE_IN_I,
  input wire logic TEMP_OPEN_I,
  input wire logic TEMP_OVER_I,
  output logic PWM_DRIVE_OUT_O,
  output logic FAULT_OUT_O,
  output logic FAULT_OE_N_O,
  output logic IRQ_O
);

  fpd_top_s s_r;
  fpd_top_s s_nxt;
  fpd_pwm_if ifc ();

  logic setup;
  logic wr;
  logic [5:0] evt_set;
  logic [5:0] w1c;
  logic start_done;
  logic [31:0] rd;
  logic hit;

  // ----------------------------------------------------------------
  // pwm core
  // ----------------------------------------------------------------
  fpd_pwm_core #(
    .SLOT_CYC(SLOT_CYC)
  ) u_core (
    .CLK_I(CLK_I),
    .RST_I(RST_I),
    .ifc(ifc.core)
  );

  assign ifc.ce = CE_I;
  assign ifc.en = (s_r.st != FPD_ST_OFF);
  assign ifc.full_on = (s_r.st != FPD_ST_RUN);

  // source follows the select bit once the start second is over
  always_comb begin
    if (s_r.cfg_src) begin
      ifc.code = s_r.duty;
    end else if (TEMP_OPEN_I) begin
      ifc.code = `FPD_DUTY_OPEN;
    end else begin
      ifc.code = TEMP_VOLTAGE_IN_I;
    end
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign setup = PSEL_I && !PENABLE_I;
  assign wr = PSEL_I && PENABLE_I && PWRITE_I && PSTRB_I[0] && CE_I;
  assign PREADY_O = CE_I;
  assign PRDATA_O = s_r.prdata;
  assign PSLVERR_O = s_r.pslverr;

  always_comb begin
    rd = 32'h00000000;
    hit = 1'b1;
    unique case (PADDR_I)
      `FPD_OFS_CFG: begin
        rd[`FPD_CFG_SHDN] = s_r.cfg_shdn;
        rd[`FPD_CFG_SRC] = s_r.cfg_src;
      end
      `FPD_OFS_DUTY: rd[3:0] = s_r.duty;
      `FPD_OFS_STAT: rd[5:0] = s_r.stat;
      `FPD_OFS_MASK: rd[5:0] = s_r.mask;
      `FPD_OFS_STATE: begin
        rd[1:0] = s_r.st;
        rd[7:4] = ifc.code;
        rd[8] = s_r.ot_live;
        rd[9] = ifc.pwm;
      end
      default: hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // events
  // ----------------------------------------------------------------
  assign start_done = (s_r.st == FPD_ST_START) && !s_r.cfg_shdn && ifc.period_end
    && (s_r.per_cnt == 5'(`FPD_START_PERIODS - 1));

  always_comb begin
    evt_set = 6'h00;
    evt_set[`FPD_ST_OTF] = TEMP_OVER_I;
    evt_set[`FPD_ST_STARTED] = start_done;
    w1c = (wr && PADDR_I == `FPD_OFS_STAT) ? (PWDATA_I[5:0] & `FPD_EVT_MASK) : 6'h00;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.ot_live = TEMP_OVER_I;
    // set wins over a clear in the same cycle
    s_nxt.stat = (s_r.stat & ~w1c) | evt_set;
    if (setup) begin
      s_nxt.prdata = PWRITE_I ? 32'h00000000 : rd;
      s_nxt.pslverr = !hit;
    end
    if (wr) begin
      unique case (PADDR_I)
        `FPD_OFS_CFG: begin
          s_nxt.cfg_shdn = PWDATA_I[`FPD_CFG_SHDN];
          s_nxt.cfg_src = PWDATA_I[`FPD_CFG_SRC];
        end
        `FPD_OFS_DUTY: s_nxt.duty = PWDATA_I[3:0];
        `FPD_OFS_MASK: s_nxt.mask = PWDATA_I[5:0] & `FPD_EVT_MASK;
        default: ;
      endcase
    end
    unique case (s_r.st)
      FPD_ST_OFF: begin
        if (!s_r.cfg_shdn) begin
          s_nxt.st = FPD_ST_START;
          s_nxt.per_cnt = 5'h00;
        end
      end
      FPD_ST_START: begin
        if (s_r.cfg_shdn) begin
          s_nxt.st = FPD_ST_OFF;
        end else if (start_done) begin
          s_nxt.st = FPD_ST_RUN;
        end else if (ifc.period_end) begin
          s_nxt.per_cnt = s_r.per_cnt + 5'h01;
        end
      end
      FPD_ST_RUN: begin
        if (s_r.cfg_shdn) begin
          s_nxt.st = FPD_ST_OFF;
        end
      end
      default: s_nxt.st = FPD_ST_OFF;
    endcase
  end

  // power-up counts as a start condition
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      s_r <= '0;
      s_r.cfg_shdn <= `FPD_CFG_RST;
      s_r.cfg_src <= `FPD_CFG_RST;
      s_r.duty <= `FPD_DUTY_RST;
      s_r.mask <= `FPD_MASK_RST;
      s_r.st <= FPD_ST_START;
    end else if (CE_I) begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  assign PWM_DRIVE_OUT_O = ifc.pwm;
  assign FAULT_OUT_O = 1'b0;
  assign FAULT_OE_N_O = !(FAULT_VARIANT && s_r.ot_live);
  assign IRQ_O = |(s_r.stat & s_r.mask);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  start_len_a: assert property (
    (CE_I && s_r.st == FPD_ST_START && ifc.period_end && !s_r.cfg_shdn
      && s_r.per_cnt == 5'(`FPD_START_PERIODS - 1)) |=> s_r.st == FPD_ST_RUN
  ) else $error("start second did not end after thirty periods");

  start_full_a: assert property (
    (CE_I && s_r.st == FPD_ST_RUN) |-> $past(s_r.st) != FPD_ST_OFF
  ) else $error("normal control entered without a start second");

  shdn_stop_a: assert property (
    (CE_I && s_r.st == FPD_ST_OFF) ##1 (CE_I && s_r.st == FPD_ST_OFF) |=> !PWM_DRIVE_OUT_O
  ) else $error("pwm output active in shutdown");

  shdn_enter_a: assert property (
    (CE_I && s_r.cfg_shdn) |=> s_r.st == FPD_ST_OFF
  ) else $error("shutdown bit did not stop the drive");

  reset_src_a: assert property (
    @(posedge CLK_I) disable iff (1'b0) RST_I |=> !s_r.cfg_src && s_r.st == FPD_ST_START
  ) else $error("reset did not select the temperature input");

  open_duty_a: assert property (
    (!s_r.cfg_src && TEMP_OPEN_I) |-> ifc.code == `FPD_DUTY_OPEN
  ) else $error("open temperature input not at default duty");

  otf_set_a: assert property (
    (CE_I && TEMP_OVER_I) |=> s_r.stat[`FPD_ST_OTF] && IRQ_O == |(s_r.stat & s_r.mask)
  ) else $error("over-temperature flag not set");

  fault_pin_a: assert property (
    (CE_I && TEMP_OVER_I) |=> (FAULT_OE_N_O == !FAULT_VARIANT)
  ) else $error("fault pin not driven during over-temperature");

  // ----------------------------------------------------------------
  // source, register and state checks
  // ----------------------------------------------------------------
  reg_src_a: assert property (
    s_r.cfg_src |-> ifc.code == s_r.duty
  ) else $error("register source not applied");

  temp_src_a: assert property (
    (!s_r.cfg_src && !TEMP_OPEN_I) |-> ifc.code == TEMP_VOLTAGE_IN_I
  ) else $error("temperature source not applied");

  duty_wr_a: assert property (
    (CE_I && PSEL_I && PENABLE_I && PWRITE_I && PSTRB_I[0] && PADDR_I == `FPD_OFS_DUTY)
      |=> s_r.duty == $past(PWDATA_I[3:0])
  ) else $error("duty write lost");

  cfg_wr_a: assert property (
    (CE_I && PSEL_I && PENABLE_I && PWRITE_I && PSTRB_I[0] && PADDR_I == `FPD_OFS_CFG)
      |=> s_r.cfg_src == $past(PWDATA_I[`FPD_CFG_SRC])
  ) else $error("source select write lost");

  start_on_a: assert property (
    (s_r.st == FPD_ST_START) |-> ifc.full_on
  ) else $error("start second not full on");

  run_code_a: assert property (
    (s_r.st == FPD_ST_RUN) |-> !ifc.full_on
  ) else $error("normal control still full on");

  run_keep_a: assert property (
    (CE_I && s_r.st == FPD_ST_RUN && !s_r.cfg_shdn) |=> s_r.st == FPD_ST_RUN
  ) else $error("drive stopped without shutdown");

  restart_a: assert property (
    (CE_I && s_r.st == FPD_ST_OFF && !s_r.cfg_shdn) |=> s_r.st == FPD_ST_START && s_r.per_cnt == 5'h00
  ) else $error("shutdown release did not restart the start second");

  per_cnt_a: assert property (
    (s_r.st == FPD_ST_START) |-> s_r.per_cnt < 5'(`FPD_START_PERIODS)
  ) else $error("start period count out of range");

  otf_sticky_a: assert property (
    (CE_I && s_r.stat[`FPD_ST_OTF] && !w1c[`FPD_ST_OTF]) |=> s_r.stat[`FPD_ST_OTF]
  ) else $error("over-temperature flag lost without clear");

  otf_clear_a: assert property (
    (CE_I && w1c[`FPD_ST_OTF] && !TEMP_OVER_I) |=> !s_r.stat[`FPD_ST_OTF]
  ) else $error("over-temperature flag not cleared");

  err_unmapped_a: assert property (
    (CE_I && PSEL_I && !PENABLE_I && !hit) |=> PSLVERR_O
  ) else $error("unmapped access without error");

endmodule : fpd_fan_pwm
`default_nettype wire

//--- hw/fpd_pkg.sv
// Purpose: types of the fan pwm drive
// Assumes: none
// Notes: constants live in fpd_regs.svh
package fpd_pkg;

  typedef enum logic [1:0] {
    FPD_ST_OFF = 2'b00,
    FPD_ST_START = 2'b01,
    FPD_ST_RUN = 2'b10
  } fpd_state_e;

  typedef struct packed {
    logic [13:0] pre;
    logic [8:0] slot;
    logic [8:0] high;
    logic out;
  } fpd_core_s;

  typedef struct packed {
    logic cfg_shdn;
    logic cfg_src;
    logic [3:0] duty;
    logic [5:0] stat;
    logic [5:0] mask;
    fpd_state_e st;
    logic [4:0] per_cnt;
    logic ot_live;
    logic [31:0] prdata;
    logic pslverr;
  } fpd_top_s;

endpackage : fpd_pkg

//--- hw/fpd_pwm_core.sv
// Purpose: fixed-period pwm generator with per-period duty latch
// Assumes: slot length fixed by parameter, 300 slots per period
// Notes: duty 30% + code * 14/3 %, or full on
`timescale 1ns/1ps
`default_nettype none
`include "fpd_regs.svh"
module fpd_pwm_core
  import fpd_pkg::*;
#(
  parameter int unsigned SLOT_CYC = `FPD_SLOT_CYC
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  fpd_pwm_if.core ifc
);

  fpd_core_s s_r;
  fpd_core_s s_nxt;
  logic boundary;
  logic last_pre;
  logic [8:0] hi_eff;

  // ----------------------------------------------------------------
  // period and slot counting
  // ----------------------------------------------------------------
  assign boundary = (s_r.pre == 14'h0000) && (s_r.slot == 9'h000);
  assign last_pre = (s_r.pre == 14'(SLOT_CYC - 1));
  assign ifc.period_end = ifc.en && last_pre && (s_r.slot == `FPD_SLOTS - 9'h001);
  assign ifc.pwm = s_r.out;

  always_comb begin
    s_nxt = s_r;
    hi_eff = s_r.high;
    if (!ifc.en) begin
      s_nxt = '0;
    end else begin
      if (last_pre) begin
        s_nxt.pre = 14'h0000;
        s_nxt.slot = (s_r.slot == `FPD_SLOTS - 9'h001) ? 9'h000 : s_r.slot + 9'h001;
      end else begin
        s_nxt.pre = s_r.pre + 14'h0001;
      end
      // new duty only at a period start
      if (boundary) begin
        hi_eff = ifc.full_on ? `FPD_SLOTS : `FPD_MIN_SLOTS + `FPD_STEP_SLOTS * {5'h00, ifc.code};
        s_nxt.high = hi_eff;
      end
      s_nxt.out = (s_r.slot < hi_eff);
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      s_r <= '0;
    end else if (ifc.ce) begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  full_on_a: assert property (
    (ifc.ce && ifc.en && s_r.high == `FPD_SLOTS && !boundary) |=> s_r.out || !ifc.en
  ) else $error("full duty period shows a low level");

  latch_hold_a: assert property (
    (ifc.ce && ifc.en && !boundary) |=> $stable(s_r.high) || !$past(ifc.en)
  ) else $error("duty changed inside a period");

  duty_min_a: assert property (
    (ifc.ce && ifc.en && boundary) |=> (s_r.high >= `FPD_MIN_SLOTS) && (s_r.high <= `FPD_SLOTS)
  ) else $error("latched duty outside 30 to 100 percent");

  core_off_a: assert property (
    (ifc.ce && !ifc.en) |=> !s_r.out && s_r.slot == 9'h000
  ) else $error("pwm active while disabled");

endmodule : fpd_pwm_core
`default_nettype wire

//--- hw/fpd_pwm_if.sv
// Purpose: link between the control top and the pwm period core
// Assumes: single clock domain
// Notes: ctrl drives the request, core answers with the waveform
`timescale 1ns/1ps
`default_nettype none
interface fpd_pwm_if;
  logic ce;
  logic en;
  logic full_on;
  logic [3:0] code;
  logic period_end;
  logic pwm;

  modport ctrl (output ce, output en, output full_on, output code, input period_end, input pwm);
  modport core (input ce, input en, input full_on, input code, output period_end, output pwm);
endinterface : fpd_pwm_if
`default_nettype wire

//--- hw/fpd_regs.svh
// Purpose: register map, field positions, reset values and timing counts of the fan pwm drive
// Assumes: 32-bit apb data, one register per aligned word
// Notes: constants only
`ifndef FPD_REGS_SVH
`define FPD_REGS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define FPD_OFS_CFG 8'h00
`define FPD_OFS_DUTY 8'h04
`define FPD_OFS_STAT 8'h08
`define FPD_OFS_MASK 8'h0c
`define FPD_OFS_STATE 8'h10

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FPD_CFG_SHDN 0
`define FPD_CFG_SRC 5
`define FPD_ST_STARTED 0
`define FPD_ST_OTF 5
`define FPD_EVT_MASK 6'h21

// ----------------------------------------------------------------
// reset values and open-input duty code
// ----------------------------------------------------------------
`define FPD_CFG_RST 1'h0
`define FPD_DUTY_RST 4'h0
`define FPD_MASK_RST 6'h00
`define FPD_DUTY_OPEN 4'h2

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define FPD_CLK_HZ 32'h05f5e100
`define FPD_PWM_HZ 32'h0000001e
`define FPD_START_MS 32'h000003e8
`define FPD_SLOTS 9'h12c
`define FPD_MIN_SLOTS 9'h05a
`define FPD_STEP_SLOTS 9'h00e
`define FPD_SLOT_CYC (`FPD_CLK_HZ / (`FPD_PWM_HZ * 32'h0000012c))
`define FPD_START_PERIODS ((`FPD_START_MS * `FPD_PWM_HZ) / 32'h000003e8)

`endif

//--- tb/fpd_fan_pwm_bench.sv
// Purpose: self-checking bench of the fan pwm drive
// Assumes: slot length 2 cycles, period 600 cycles
// Notes: duty measured as on-cycles over a whole period window
`timescale 1ns/1ps
`default_nettype none
`include "fpd_regs.svh"
module fpd_fan_pwm_bench;
  import fpd_pkg::*;
  localparam int SC = 2;
  localparam int PER = 300 * SC;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, clr = 1'b0, ce = 1'b1, hold;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwd = 32'h0, prd, cnt, rd;
  logic [3:0] tv = 4'h0;
  logic topen = 1'b0, tover = 1'b0, pready, perr, pwm, fout, foe_n, irq;
  int n_fail = 0, checks_done = 0;
  always #5 clk = ~clk;
  fpd_fan_pwm #(.SLOT_CYC(SC), .FAULT_VARIANT(1'b1)) u_dut (.CLK_I(clk), .RST_I(rst), .CE_I(ce),
    .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwd), .PSTRB_I(4'hf),
    .PRDATA_O(prd), .PREADY_O(pready), .PSLVERR_O(perr), .TEMP_VOLTAGE_IN_I(tv), .TEMP_OPEN_I(topen),
    .TEMP_OVER_I(tover), .PWM_DRIVE_OUT_O(pwm), .FAULT_OUT_O(fout), .FAULT_OE_N_O(foe_n), .IRQ_O(irq));
  fpd_fan_switch_model u_fan (.clk_i(clk), .clr_i(clr), .gate_i(pwm), .on_cnt_o(cnt));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prd;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic settle(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : settle
  task automatic meas(input int len, input logic [31:0] exp, input string msg);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    settle(len);
    chk(cnt, exp, msg);
  endtask : meas
  function automatic logic [31:0] hi(input int code);
    return 32'((90 + 14 * code) * SC);
  endfunction : hi
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    settle(0);
    chk(pwm, 1'b0, "pwm in reset");
    chk(foe_n, 1'b1, "fault in reset");
    chk(irq, 1'b0, "irq in reset");
  endtask : t_reset
  task automatic t_start;
    @(posedge clk);
    rst <= 1'b0;
    settle(2);
    meas(28 * PER, 28 * PER, "start full on");
    settle(3 * PER);
    apb(1'b0, `FPD_OFS_STATE, 32'h0);
    chk(rd[1:0], 2'h2, "run after 30 periods");
    apb(1'b0, `FPD_OFS_CFG, 32'h0);
    chk(rd, 32'h0, "cfg reset, analog source");
    apb(1'b0, `FPD_OFS_STAT, 32'h0);
    chk(rd, 32'h1, "start done flag");
  endtask : t_start
  task automatic t_overtemp;
    apb(1'b1, `FPD_OFS_STAT, 32'h21);
    tover <= 1'b1;
    settle(3);
    chk({fout, foe_n}, 2'b00, "fault pin low");
    chk(irq, 1'b0, "masked");
    apb(1'b0, `FPD_OFS_STAT, 32'h0);
    chk(rd, 32'h20, "over flag set");
    apb(1'b1, `FPD_OFS_MASK, 32'h20);
    tover <= 1'b0;
    settle(3);
    chk({irq, foe_n}, 2'b11, "sticky irq, fault gone");
    apb(1'b1, `FPD_OFS_STAT, 32'h20);
    settle(3);
    chk(irq, 1'b0, "irq cleared");
    apb(1'b0, `FPD_OFS_STAT, 32'h0);
    chk(rd, 32'h0, "flag cleared");
  endtask : t_overtemp
  task automatic t_analog;
    topen <= 1'b1;
    tv <= 4'h9;
    settle(2 * PER);
    meas(PER, hi(2), "open input duty");
    topen <= 1'b0;
    tv <= 4'h5;
    settle(2 * PER);
    meas(PER, hi(5), "analog duty");
  endtask : t_analog
  task automatic t_freeze;
    @(posedge clk);
    ce <= 1'b0;
    settle(3);
    hold = pwm;
    chk(pready, 1'b0, "ready low while frozen");
    settle(40);
    chk(pwm, hold, "pwm frozen");
    @(posedge clk);
    ce <= 1'b1;
    settle(2);
    chk(pready, 1'b1, "ready back");
  endtask : t_freeze
  task automatic t_regduty;
    apb(1'b1, `FPD_OFS_CFG, 32'h20);
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, `FPD_OFS_DUTY, 32'(c));
      apb(1'b0, `FPD_OFS_DUTY, 32'h0);
      chk(rd, 32'(c), "duty readback");
      settle(2 * PER);
      meas(PER, hi(c), "register duty");
    end
  endtask : t_regduty
  task automatic t_unmapped;
    apb(1'b1, 8'h3c, 32'hffffffff);
    chk(perr, 1'b1, "unmapped write error");
    apb(1'b0, 8'h3c, 32'h0);
    chk({perr, rd}, {1'b1, 32'h0}, "unmapped read");
  endtask : t_unmapped
  task automatic t_shutdown;
    apb(1'b1, `FPD_OFS_DUTY, 32'h0);
    apb(1'b1, `FPD_OFS_CFG, 32'h21);
    settle(3);
    meas(PER, 32'h0, "shutdown stops pwm");
    apb(1'b1, `FPD_OFS_CFG, 32'h20);
    settle(3);
    meas(PER, PER, "restart full on");
    apb(1'b0, `FPD_OFS_STATE, 32'h0);
    chk(rd[1:0], 2'h1, "start state again");
  endtask : t_shutdown
  // ----------------------------------------------------------------
  // sequence and verdict
  // ----------------------------------------------------------------
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (8) @(posedge clk);
    t_reset();
    t_start();
    t_overtemp();
    t_analog();
    t_freeze();
    t_regduty();
    t_unmapped();
    t_shutdown();
    conclude();
  end
  initial begin
    #900000;
    n_fail++;
    $display("ERROR %0t watchdog expired", $time);
    conclude();
  end
endmodule : fpd_fan_pwm_bench
`default_nettype wire

//--- tb/fpd_fan_switch_model.sv
// Purpose: fan switch seen from the pwm pin, counts on-cycles
// Assumes: gate high turns the switch on
// Notes: count cleared by clr_i
`timescale 1ns/1ps
`default_nettype none
module fpd_fan_switch_model (
  input wire logic clk_i,
  input wire logic clr_i,
  input wire logic gate_i,
  output logic [31:0] on_cnt_o
);
  always_ff @(posedge clk_i) begin
    if (clr_i) begin
      on_cnt_o <= 32'h0;
    end else if (gate_i) begin
      on_cnt_o <= on_cnt_o + 32'h1;
    end
  end
endmodule : fpd_fan_switch_model
`default_nettype wire
